// *** ulpirg_pkg.sv ***
/*
 * Package for the link-side register bank: register addresses, field positions,
 * reset values and timing figures.
 * Assumes a single 25 MHz system clock; the link reaches the bank through a
 * simple address/data port that the surrounding interface logic decodes.
 */
package ulpirg_pkg;
	localparam int unsigned   ULPIRG_ADDR_W  = 6;
	localparam int unsigned   ULPIRG_DATA_W  = 8;
	localparam int unsigned   ULPIRG_NUM_SRC = 5;

	// write, set, clear addresses of the four control registers, read decodes all three; then the status and latch read addresses
	localparam logic [5:0] ULPIRG_IFC_WR  = 6'h07;
	localparam logic [5:0] ULPIRG_IFC_SET = 6'h08;
	localparam logic [5:0] ULPIRG_IFC_CLR = 6'h09;
	localparam logic [5:0] ULPIRG_DRC_WR  = 6'h0A;
	localparam logic [5:0] ULPIRG_DRC_SET = 6'h0B;
	localparam logic [5:0] ULPIRG_DRC_CLR = 6'h0C;
	localparam logic [5:0] ULPIRG_RIS_WR  = 6'h0D;
	localparam logic [5:0] ULPIRG_RIS_SET = 6'h0E;
	localparam logic [5:0] ULPIRG_RIS_CLR = 6'h0F;
	localparam logic [5:0] ULPIRG_FAL_WR  = 6'h10;
	localparam logic [5:0] ULPIRG_FAL_SET = 6'h11;
	localparam logic [5:0] ULPIRG_FAL_CLR = 6'h12;
	localparam logic [5:0] ULPIRG_STAT    = 6'h13;
	localparam logic [5:0] ULPIRG_LATCH   = 6'h14;

	// reset values and the implemented mask of the edge enables
	localparam logic [7:0] ULPIRG_IFC_RST = 8'h00;
	localparam logic [7:0] ULPIRG_DRC_RST = 8'h06;
	localparam logic [7:0] ULPIRG_EDG_RST = 8'h1F;
	localparam logic [7:0] ULPIRG_EDG_MSK = 8'h1F;

	// interface configuration fields
	localparam int unsigned ULPIRG_B_SIX   = 0;
	localparam int unsigned ULPIRG_B_THREE = 1;
	localparam int unsigned ULPIRG_B_CAR   = 2;
	localparam int unsigned ULPIRG_B_CLKH  = 3;
	localparam int unsigned ULPIRG_B_AUTOW = 4;
	localparam int unsigned ULPIRG_B_INV   = 5;
	localparam int unsigned ULPIRG_B_BYP   = 6;
	localparam int unsigned ULPIRG_B_STPD  = 7;

	// dual-role control fields
	localparam int unsigned ULPIRG_B_IDPU  = 0;
	localparam int unsigned ULPIRG_B_DPPD  = 1;
	localparam int unsigned ULPIRG_B_DMPD  = 2;
	localparam int unsigned ULPIRG_B_DIS   = 3;
	localparam int unsigned ULPIRG_B_CHG   = 4;
	localparam int unsigned ULPIRG_B_DRV   = 5;
	localparam int unsigned ULPIRG_B_DRVA  = 6;
	localparam int unsigned ULPIRG_B_EXTS  = 7;

	// event sources, in latch bit order
	localparam int unsigned ULPIRG_S_HDIS  = 0;
	localparam int unsigned ULPIRG_S_PWR   = 1;
	localparam int unsigned ULPIRG_S_SESS  = 2;
	localparam int unsigned ULPIRG_S_SEND  = 3;
	localparam int unsigned ULPIRG_S_IDENT_TIED_LOW = 4;

	localparam int unsigned ULPIRG_CLK_MHZ = 25;

	typedef enum logic [1:0] {
		ULPIRG_OP_WRITE,
		ULPIRG_OP_SET,
		ULPIRG_OP_CLEAR,
		ULPIRG_OP_NONE
	} ulpirg_op_t;
endpackage

// *** ulpirg_reg8.sv ***
/*
 * One 8-bit register with write, set and clear operations plus a hardware
 * clear mask. Bits outside the implemented mask hold zero from the first clock after reset; reset loads RST_VAL unmasked.
 * Assumes the op code is decoded by the caller and is valid for one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module ulpirg_reg8
	import ulpirg_pkg::*;
#(
	parameter logic [7:0] RST_VAL  = 8'h00,
	parameter logic [7:0] IMPL_MSK = 8'hFF
) (
	input  wire logic       i_clk,
	input  wire logic       i_reset,
	input  wire ulpirg_op_t i_op,
	input  wire logic [7:0] i_data,
	input  wire logic [7:0] i_hw_clr,
	output logic      [7:0] o_value
);
	logic [7:0] value_r;
	logic [7:0] value_nxt;
	logic [7:0] sw_val;

	always_comb begin
		unique case (i_op)
			ULPIRG_OP_WRITE: sw_val = i_data;
			ULPIRG_OP_SET:   sw_val = value_r | i_data;
			ULPIRG_OP_CLEAR: sw_val = value_r & ~i_data;
			ULPIRG_OP_NONE:  sw_val = value_r;
		endcase
	end

	// a link write in the same cycle as a hardware exit still leaves the exit visible
	assign value_nxt = sw_val & ~i_hw_clr & IMPL_MSK;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			value_r <= RST_VAL;
		end else begin
			value_r <= value_nxt;
		end
	end

	assign o_value = value_r;
endmodule
`default_nettype wire

// *** ulpirg_bank.sv ***
/*
 * Link-accessible control register bank: interface configuration, dual-role
 * line control, and rising/falling edge event enables, with the event latch
 * and live status they steer.
 * Assumes the ULPI framing logic presents one decoded register access per
 * cycle (i_wr_en, i_rd_en with i_addr) synchronous to i_clk, and that the
 * analog comparators and mode-exit strobes arrive synchronous to i_clk.
 * A mode-exit strobe wins over a link write of the same mode bit, and an
 * edge event wins over the read that clears the latch, so neither is lost.
 * The first cycle after reset raises no events: there is no prior sample yet.
 */
// Summary of operation
// - interface config: read 07-09, write/set/clear
// - dual-role control: read 0A-0C, write/set/clear
// - rising enables: read 0D-0F, write/set/clear
// - falling enables: read 10-12, write/set/clear
// - bit0 selects six-wire serial, auto-cleared
// - bit1 selects three-wire serial, auto-cleared
// - bit2 selects car accessory mode, auto-cleared
// - bit3 keeps clock running in alternate modes
// - bit4 auto resume, host operation only
// - bit5 inverts external power flag
// - bit6 bypasses AND with internal comparator
// - bit7 disables stop-pin protection pull-up
// - dual-role bit0 drives ident pull-up enable
// - bits1,2 enable D+/D- pull-downs, reset one
// - bit3 connects bus-power discharge resistor
// - bit4 connects bus-power charge resistor
// - charge pump on when bit5 or bit6
// - bit7 picks external flag as power-valid
// - rising enables bits0-4 unmask, reset one
// - host-detach host only; bits7-5 read zero
// - falling enables bits0-2 unmask, reset one
// - falling bits3-4 unmask, reset one, upper zero
// - unmasked edge sets latch; read clears
`timescale 1ns/1ps
`default_nettype none
module ulpirg_bank
	import ulpirg_pkg::*;
(
	input  wire logic                     i_clk,
	input  wire logic                     i_reset,
	input  wire logic [ULPIRG_ADDR_W-1:0] i_addr,
	input  wire logic                     i_wr_en,
	input  wire logic [ULPIRG_DATA_W-1:0] i_wr_data,
	input  wire logic                     i_rd_en,
	output logic      [ULPIRG_DATA_W-1:0] o_rd_data,
	output logic                          o_rd_valid,
	input  wire logic                     i_host_mode,
	input  wire logic                     i_serial_exit,
	input  wire logic                     i_car_exit,
	input  wire logic                     i_host_detach,
	input  wire logic                     i_power_cmp,
	input  wire logic                     i_ext_power_flag_in,
	input  wire logic                     i_session_ok,
	input  wire logic                     i_session_over,
	input  wire logic                     i_ident_tied_low,
	output logic                          o_six_wire_serial_select,
	output logic                          o_three_wire_serial_select,
	output logic                          o_car_accessory_select,
	output logic                          o_link_clock_run,
	output logic                          o_auto_wake_signal,
	output logic                          o_stop_pullup_enable,
	output logic                          o_ident_pin_pullup_en,
	output logic                          o_dplus_pulldown_en,
	output logic                          o_dminus_pulldown_en,
	output logic                          o_bus_power_discharge,
	output logic                          o_bus_power_charge,
	output logic                          o_charge_pump_enable_out,
	output logic                          o_power_valid
);
	////////////////////////////////////////////////////////////////////////
	// access decode

	// set and clear sit at the same steps above the write address of every trio
	localparam logic [5:0] SET_STEP = ULPIRG_IFC_SET - ULPIRG_IFC_WR;
	localparam logic [5:0] CLR_STEP = ULPIRG_IFC_CLR - ULPIRG_IFC_WR;

	function automatic ulpirg_op_t op_of(input logic [5:0] addr, input logic [5:0] base, input logic wr);
		ulpirg_op_t op;
		op = ULPIRG_OP_NONE;
		if (wr && addr == base) begin
			op = ULPIRG_OP_WRITE;
		end else if (wr && addr == base + SET_STEP) begin
			op = ULPIRG_OP_SET;
		end else if (wr && addr == base + CLR_STEP) begin
			op = ULPIRG_OP_CLEAR;
		end
		return op;
	endfunction

	function automatic logic in_trio(input logic [5:0] addr, input logic [5:0] base);
		return (addr >= base) && (addr <= base + CLR_STEP);
	endfunction

	ulpirg_op_t ifc_op;
	ulpirg_op_t drc_op;
	ulpirg_op_t ris_op;
	ulpirg_op_t fal_op;

	// each register answers only to its own three write addresses
	assign ifc_op = op_of(i_addr, ULPIRG_IFC_WR, i_wr_en);
	assign drc_op = op_of(i_addr, ULPIRG_DRC_WR, i_wr_en);
	assign ris_op = op_of(i_addr, ULPIRG_RIS_WR, i_wr_en);
	assign fal_op = op_of(i_addr, ULPIRG_FAL_WR, i_wr_en);

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [7:0] ifc_val;
	logic [7:0] drc_val;
	logic [7:0] ris_val;
	logic [7:0] fal_val;
	logic [7:0] ifc_hw_clr;

	// mode bits drop on the exit strobe of the mode they select
	assign ifc_hw_clr = {5'h00,
		i_car_exit,
		i_serial_exit,
		i_serial_exit};

	ulpirg_reg8 #(.RST_VAL(ULPIRG_IFC_RST), .IMPL_MSK(8'hFF)) u_ifc (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_op    (ifc_op),
		.i_data  (i_wr_data),
		.i_hw_clr(ifc_hw_clr),
		.o_value (ifc_val)
	);

	// line control has no hardware clear: only the link changes it
	ulpirg_reg8 #(.RST_VAL(ULPIRG_DRC_RST), .IMPL_MSK(8'hFF)) u_drc (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_op    (drc_op),
		.i_data  (i_wr_data),
		.i_hw_clr(8'h00),
		.o_value (drc_val)
	);

	// the upper three enable bits are never stored, so they read as zero
	ulpirg_reg8 #(.RST_VAL(ULPIRG_EDG_RST), .IMPL_MSK(ULPIRG_EDG_MSK)) u_ris (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_op    (ris_op),
		.i_data  (i_wr_data),
		.i_hw_clr(8'h00),
		.o_value (ris_val)
	);

	ulpirg_reg8 #(.RST_VAL(ULPIRG_EDG_RST), .IMPL_MSK(ULPIRG_EDG_MSK)) u_fal (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_op    (fal_op),
		.i_data  (i_wr_data),
		.i_hw_clr(8'h00),
		.o_value (fal_val)
	);

	////////////////////////////////////////////////////////////////////////
	// control outputs

	logic ext_flag;
	logic qualified_flag;
	logic alt_mode;

	assign o_six_wire_serial_select   = ifc_val[ULPIRG_B_SIX];
	assign o_three_wire_serial_select = ifc_val[ULPIRG_B_THREE];
	assign o_car_accessory_select     = ifc_val[ULPIRG_B_CAR];

	assign alt_mode         = |ifc_val[ULPIRG_B_CAR:ULPIRG_B_SIX];
	// outside alternate modes the clock always runs
	assign o_link_clock_run = ~alt_mode | ifc_val[ULPIRG_B_CLKH];
	assign o_auto_wake_signal   = ifc_val[ULPIRG_B_AUTOW] & i_host_mode;
	assign o_stop_pullup_enable = ~ifc_val[ULPIRG_B_STPD];

	// the external flag follows its input, flipped by the invert bit; the bypass bit skips the AND with the comparator
	assign ext_flag       = i_ext_power_flag_in ^ ifc_val[ULPIRG_B_INV];
	assign qualified_flag = ifc_val[ULPIRG_B_BYP] ? ext_flag : (ext_flag & i_power_cmp);
	assign o_power_valid  = drc_val[ULPIRG_B_EXTS] ? qualified_flag : i_power_cmp;

	assign o_ident_pin_pullup_en    = drc_val[ULPIRG_B_IDPU];
	assign o_dplus_pulldown_en      = drc_val[ULPIRG_B_DPPD];
	assign o_dminus_pulldown_en     = drc_val[ULPIRG_B_DMPD];
	assign o_bus_power_discharge    = drc_val[ULPIRG_B_DIS];
	assign o_bus_power_charge       = drc_val[ULPIRG_B_CHG];
	assign o_charge_pump_enable_out = drc_val[ULPIRG_B_DRV] | drc_val[ULPIRG_B_DRVA];

	////////////////////////////////////////////////////////////////////////
	// edge events and latch

	logic [ULPIRG_NUM_SRC-1:0] src_now;
	logic [ULPIRG_NUM_SRC-1:0] src_prev_r;
	logic [ULPIRG_NUM_SRC-1:0] src_live;
	logic [ULPIRG_NUM_SRC-1:0] rise_evt;
	logic [ULPIRG_NUM_SRC-1:0] fall_evt;
	logic [ULPIRG_NUM_SRC-1:0] evt;
	logic [ULPIRG_NUM_SRC-1:0] latch_r;
	logic [ULPIRG_NUM_SRC-1:0] latch_nxt;
	logic                      latch_rd;
	logic                      prev_ok_r;
	logic [ULPIRG_NUM_SRC-1:0] evt_raw;

	assign src_live = {i_ident_tied_low, i_session_over, i_session_ok, o_power_valid, i_host_detach};
	// host detach is held low outside host operation; there it raises only a falling event, when host mode ends while it is high
	assign src_now  = {src_live[ULPIRG_NUM_SRC-1:1], src_live[ULPIRG_S_HDIS] & i_host_mode};

	assign rise_evt = src_now & ~src_prev_r & ris_val[ULPIRG_NUM_SRC-1:0];
	assign fall_evt = ~src_now & src_prev_r & fal_val[ULPIRG_NUM_SRC-1:0];
	assign evt_raw  = rise_evt | fall_evt;
	// no events on the first cycle after reset: the previous sample is not yet real
	assign evt      = prev_ok_r ? evt_raw : '0;

	assign latch_rd  = i_rd_en && (i_addr == ULPIRG_LATCH);
	// a new event wins over the read that clears the latch
	assign latch_nxt = (latch_rd ? '0 : latch_r) | evt;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			src_prev_r <= '0;
		end else begin
			src_prev_r <= src_now;
		end
	end

	// marks that src_prev_r holds a real sample
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			prev_ok_r <= 1'b0;
		end else begin
			prev_ok_r <= 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			latch_r <= '0;
		end else begin
			latch_r <= latch_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path

	localparam int unsigned PAD_W = ULPIRG_DATA_W - ULPIRG_NUM_SRC;

	logic [7:0] rd_mux;
	logic [7:0] rd_data_r;
	logic       rd_valid_r;
	logic [7:0] stat_word;
	logic [7:0] latch_word;
	logic       sel_ifc;
	logic       sel_drc;
	logic       sel_ris;
	logic       sel_fal;
	logic       sel_stat;
	logic       sel_latch;

	assign stat_word  = {{PAD_W{1'b0}}, src_now};
	assign latch_word = {{PAD_W{1'b0}}, latch_r};
	assign sel_ifc    = in_trio(i_addr, ULPIRG_IFC_WR);
	assign sel_drc    = in_trio(i_addr, ULPIRG_DRC_WR);
	assign sel_ris    = in_trio(i_addr, ULPIRG_RIS_WR);
	assign sel_fal    = in_trio(i_addr, ULPIRG_FAL_WR);
	assign sel_stat   = (i_addr == ULPIRG_STAT);
	assign sel_latch  = (i_addr == ULPIRG_LATCH);

	// address windows never overlap, so an or of gated words needs no priority;
	// unmapped addresses select nothing and read as zero
	assign rd_mux = ({ULPIRG_DATA_W{sel_ifc}} & ifc_val)
		| ({ULPIRG_DATA_W{sel_drc}} & drc_val)
		| ({ULPIRG_DATA_W{sel_ris}} & ris_val)
		| ({ULPIRG_DATA_W{sel_fal}} & fal_val)
		| ({ULPIRG_DATA_W{sel_stat}} & stat_word)
		| ({ULPIRG_DATA_W{sel_latch}} & latch_word);

	// one valid pulse per read strobe, back to back allowed
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= i_rd_en;
		end
	end

	// data hold until the next read so the link may pick them up late
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			rd_data_r <= 8'h00;
		end else if (i_rd_en) begin
			rd_data_r <= rd_mux;
		end
	end

	assign o_rd_data  = rd_data_r;
	assign o_rd_valid = rd_valid_r;
endmodule
`default_nettype wire

// *** ulpirg_bank_asserts.sv ***
/* port checker for ulpirg_bank.
   assumes it is bound into every ulpirg_bank instance. */
`timescale 1ns/1ps
`default_nettype none
module ulpirg_bank_asserts
	import ulpirg_pkg::*;
(
	input wire logic       i_clk,
	input wire logic       i_reset,
	input wire logic [5:0] i_addr,
	input wire logic       i_wr_en,
	input wire logic [7:0] i_wr_data,
	input wire logic       i_rd_en,
	input wire logic       o_rd_valid,
	input wire logic       i_serial_exit,
	input wire logic       i_car_exit,
	input wire logic       o_six_wire_serial_select,
	input wire logic       o_three_wire_serial_select,
	input wire logic       o_car_accessory_select,
	input wire logic       o_link_clock_run,
	input wire logic       o_ident_pin_pullup_en,
	input wire logic       o_dplus_pulldown_en,
	input wire logic       o_dminus_pulldown_en,
	input wire logic       o_bus_power_charge,
	input wire logic       o_charge_pump_enable_out
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// exit strobes win over a link write, so plain writes exclude them
	wire ifc_w = i_wr_en && i_addr == ULPIRG_IFC_WR && !i_serial_exit && !i_car_exit;
	wire drc_w = i_wr_en && i_addr == ULPIRG_DRC_WR;
	wire drc_s = i_wr_en && i_addr == ULPIRG_DRC_SET;
	wire drc_c = i_wr_en && i_addr == ULPIRG_DRC_CLR;
	wire run_w = !(|i_wr_data[2:0]) || i_wr_data[3];
	wire [2:0] mode_w = i_wr_data[2:0];
	wire [2:0] drc_lo = i_wr_data[2:0];
	wire [1:0] pump_w = i_wr_data[6:5];

	a_rdvalid_pulse: assert property (i_rd_en |=> o_rd_valid) else $error("read valid missing");
	a_rdvalid_idle: assert property (!i_rd_en |=> !o_rd_valid) else $error("read valid unasked");
	a_pump_or: assert property (drc_w |=> o_charge_pump_enable_out == |$past(pump_w))
		else $error("pump enable wrong");
	a_drc_write: assert property (drc_w |=>
		{o_dminus_pulldown_en, o_dplus_pulldown_en, o_ident_pin_pullup_en} == $past(drc_lo))
		else $error("line control write wrong");
	a_set_or: assert property (drc_s |=>
		o_dplus_pulldown_en == ($past(o_dplus_pulldown_en) | $past(i_wr_data[1])))
		else $error("set did not or");
	a_clear_and: assert property (drc_c |=>
		o_bus_power_charge == ($past(o_bus_power_charge) & !$past(i_wr_data[4])))
		else $error("clear did not drop");
	a_ifc_write: assert property (ifc_w |=> o_link_clock_run == $past(run_w) &&
		{o_car_accessory_select, o_three_wire_serial_select, o_six_wire_serial_select} == $past(mode_w))
		else $error("config write wrong");
	a_serial_exit: assert property (i_serial_exit |=>
		!o_six_wire_serial_select && !o_three_wire_serial_select) else $error("serial bits kept");
	a_car_exit: assert property (i_car_exit |=> !o_car_accessory_select) else $error("car bit kept");
	a_reset_vals: assert property ($fell(i_reset) |-> o_dplus_pulldown_en && o_dminus_pulldown_en
		&& !o_charge_pump_enable_out && o_link_clock_run) else $error("reset outputs wrong");
endmodule

bind ulpirg_bank ulpirg_bank_asserts u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
	.i_wr_en(i_wr_en), .i_wr_data(i_wr_data), .i_rd_en(i_rd_en), .o_rd_valid(o_rd_valid),
	.i_serial_exit(i_serial_exit), .i_car_exit(i_car_exit),
	.o_six_wire_serial_select(o_six_wire_serial_select),
	.o_three_wire_serial_select(o_three_wire_serial_select),
	.o_car_accessory_select(o_car_accessory_select), .o_link_clock_run(o_link_clock_run),
	.o_ident_pin_pullup_en(o_ident_pin_pullup_en), .o_dplus_pulldown_en(o_dplus_pulldown_en),
	.o_dminus_pulldown_en(o_dminus_pulldown_en), .o_bus_power_charge(o_bus_power_charge),
	.o_charge_pump_enable_out(o_charge_pump_enable_out));
`default_nettype wire

// *** ulpirg_link_model.sv ***
/* link-side partner: issues single-byte register reads and writes.
   assumes ulpirg_bank strobes, changed at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module ulpirg_link_model
	import ulpirg_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rd_data,
	input  wire logic       i_rd_valid,
	output var  logic [5:0] o_addr,
	output var  logic       o_wr_en,
	output var  logic [7:0] o_wr_data,
	output var  logic       o_rd_en
);
	initial begin
		o_addr = 6'h00;
		o_wr_en = 1'b0;
		o_wr_data = 8'h00;
		o_rd_en = 1'b0;
	end
	// idle bus shows inverted values so stale data never passes
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_wr_data = d;
		o_wr_en = 1'b1;
		@(negedge i_clk);
		o_wr_en = 1'b0;
		o_addr = ~a;
		o_wr_data = ~d;
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(negedge i_clk);
		o_addr = a;
		o_rd_en = 1'b1;
		@(negedge i_clk);
		o_rd_en = 1'b0;
		o_addr = ~a;
		d = (i_rd_valid === 1'b1) ? i_rd_data : 8'hXX;
	endtask
endmodule
`default_nettype wire

// *** ulpirg_bank_test.sv ***
/* self-checking bench for ulpirg_bank with the link model.
   assumes a 25 MHz clock and synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module ulpirg_bank_test
	import ulpirg_pkg::*;
();
	logic       i_clk = 1'b0;
	logic       i_reset = 1'b1;
	logic       host = 1'b0;
	logic       ext = 1'b0;
	logic       sexit = 1'b0;
	logic       cexit = 1'b0;
	logic [4:0] src = 5'h00;
	logic [7:0] seed = 8'h55;
	logic [7:0] rv;
	logic [7:0] m [4];
	int         err_total = 0;
	int         checked = 0;
	int         a, p, s;
	wire  [5:0] addr;
	wire  [7:0] wdata, rdata;
	wire        wr_en, rd_en, rvalid, six, three, car, crun, wake, stpu;
	wire        idpu, dppd, dmpd, dis, chg, pump, pv;

	always #20 i_clk = ~i_clk;

	ulpirg_bank dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(addr), .i_wr_en(wr_en),
		.i_wr_data(wdata), .i_rd_en(rd_en), .o_rd_data(rdata), .o_rd_valid(rvalid),
		.i_host_mode(host), .i_serial_exit(sexit), .i_car_exit(cexit), .i_host_detach(src[0]),
		.i_power_cmp(src[1]), .i_ext_power_flag_in(ext), .i_session_ok(src[2]),
		.i_session_over(src[3]), .i_ident_tied_low(src[4]), .o_six_wire_serial_select(six),
		.o_three_wire_serial_select(three), .o_car_accessory_select(car), .o_link_clock_run(crun),
		.o_auto_wake_signal(wake), .o_stop_pullup_enable(stpu), .o_ident_pin_pullup_en(idpu),
		.o_dplus_pulldown_en(dppd), .o_dminus_pulldown_en(dmpd), .o_bus_power_discharge(dis),
		.o_bus_power_charge(chg), .o_charge_pump_enable_out(pump), .o_power_valid(pv));
	ulpirg_link_model u_link (.i_clk(i_clk), .i_rd_data(rdata), .i_rd_valid(rvalid), .o_addr(addr),
		.o_wr_en(wr_en), .o_wr_data(wdata), .o_rd_en(rd_en));

	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic logic [7:0] nx(input logic [7:0] o, input logic [5:0] wa, input logic [7:0] d);
		logic [7:0] k;
		k = (wa >= 6'h0D) ? 8'h1F : 8'hFF;
		case ((wa - 6'h07) % 3)
			0: return d & k;
			1: return (o | d) & k;
			default: return o & ~d;
		endcase
	endfunction
	function automatic logic [7:0] ex(input logic [5:0] ra);
		return (ra >= 6'h07 && ra <= 6'h12) ? m[(ra - 6'h07) / 3] : 8'h00;
	endfunction
	function automatic logic pvx();
		logic f;
		f = ext ^ m[0][5];
		return m[1][7] ? (m[0][6] ? f : f & src[1]) : src[1];
	endfunction
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [5:0] ra);
		u_link.rd(ra, rv);
		chk("read", {8'h00, ex(ra)}, {8'h00, rv});
	endtask
	task automatic wm(input logic [5:0] wa, input logic [7:0] d);
		u_link.wr(wa, d);
		if (wa >= 6'h07 && wa <= 6'h12)
			m[(wa - 6'h07) / 3] = nx(m[(wa - 6'h07) / 3], wa, d);
	endtask
	task automatic report_and_stop();
		if (err_total == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		m = '{8'h00, 8'h06, 8'h1F, 8'h1F};
		repeat (3) @(posedge i_clk);
		@(negedge i_clk);
		i_reset = 1'b0;
		for (a = 7; a <= 18; a++) rchk(6'(a));
		rchk(6'h15);
		for (int i = 0; i < 80; i++) begin
			seed = lfsr(seed);
			a = seed % 13;
			seed = lfsr(seed);
			{host, ext, src} = seed[6:0];
			seed = lfsr(seed);
			wm((a < 12) ? 6'(a + 7) : 6'h3F, seed);
			rchk(6'(7 + a % 12));
			chk("outputs", {3'b000, m[1][4:0], |m[1][6:5], ~m[0][7], m[0][4] & host,
				!(|m[0][2:0]) || m[0][3], m[0][2:0], pvx()}, {3'b000, chg, dis, dmpd, dppd, idpu, pump,
				stpu, wake, crun, car, three, six, pv});
		end
		wm(6'h07, 8'h07);
		@(negedge i_clk) sexit = 1'b1;
		@(negedge i_clk) sexit = 1'b0;
		m[0] = m[0] & 8'hFC;
		rchk(6'h07);
		@(negedge i_clk) cexit = 1'b1;
		@(negedge i_clk) cexit = 1'b0;
		m[0][2] = 1'b0;
		rchk(6'h08);
		// line control back to its reset value 06 so the power source follows the comparator
		wm(6'h0A, 8'h06);
		src = 5'h00;
		for (p = 0; p < 3; p++) for (s = 0; s < 5; s++) begin
			wm(6'h0D, (p == 0) ? 8'h1F : 8'h00);
			wm(6'h10, (p == 0) ? 8'h00 : 8'h1F);
			host = (p < 2);
			u_link.rd(6'h14, rv);
			@(negedge i_clk) src = 5'(1 << s);
			@(negedge i_clk) src = 5'h00;
			repeat (2) @(negedge i_clk);
			u_link.rd(6'h14, rv);
			chk("latch", (p == 2 && s == 0) ? 16'h0000 : 16'(1 << s), {8'h00, rv});
			u_link.rd(6'h14, rv);
			chk("latch", 16'h0000, {8'h00, rv});
		end
		report_and_stop();
	end

	initial begin
		repeat (5000) @(posedge i_clk);
		err_total++;
		report_and_stop();
	end
endmodule
`default_nettype wire
